//--- hw/ttl_trig_pkg.sv
// shared constants for the ttl input action trigger block
package ttl_trig_pkg;

  // channel count and register bus widths
  localparam int unsigned NUM_IN   = 8;
  localparam int unsigned ADR_W    = 4;
  localparam int unsigned DAT_W    = 32;

  // system clock rate in hertz
  localparam longint unsigned CLK_HZ = 250_000_000;

  // pulse width limits in milliseconds
  localparam longint unsigned REJECT_MS = 4;
  localparam longint unsigned ACCEPT_MS = 50;
  // qualification point, strictly between the two limits
  localparam longint unsigned QUAL_MS   = 10;

  // cycles per limit; the reject bound rounds down, accept rounds up
  localparam longint unsigned REJECT_CYC = (CLK_HZ * REJECT_MS) / 1000;
  localparam longint unsigned ACCEPT_CYC = (CLK_HZ * ACCEPT_MS + 999) / 1000;
  localparam longint unsigned QUAL_CYC   = (CLK_HZ * QUAL_MS + 999) / 1000;

  // width of the pulse width counter
  localparam int unsigned CNT_W = 24;

  // register byte offsets
  localparam logic [ADR_W-1:0] OFS_MODE   = 4'h0;
  localparam logic [ADR_W-1:0] OFS_KIND   = 4'h4;
  localparam logic [ADR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADR_W-1:0] OFS_EVENT  = 4'hC;

  // field layout: two mode bits per channel, bit 1 pulse, bit 0 invert
  localparam int unsigned MODE_BITS  = 2;
  localparam int unsigned MODE_INV   = 0;
  localparam int unsigned MODE_PULSE = 1;
  // status: levels low byte, active states next byte
  localparam int unsigned STAT_ACT_LSB = 8;
  // events: turn-on low byte, turn-off next byte
  localparam int unsigned EVT_OFF_LSB  = 8;

  // trigger types
  typedef enum logic [1:0] {
    TRIG_EDGE      = 2'b00,
    TRIG_EDGE_INV  = 2'b01,
    TRIG_PULSE     = 2'b10,
    TRIG_PULSE_INV = 2'b11
  } trig_e;

  // reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [7:0]  KIND_RST = 8'hFF;
  // idle level of an undriven ttl line
  localparam logic        LINE_RST = 1'b1;

endpackage

//--- hw/chan_if.sv
// per-channel link between the register block and a conditioner
interface chan_if;
  import ttl_trig_pkg::*;

  trig_e mode;       // selected trigger type
  logic  two_state;  // action has separate on and off states
  logic  level;      // synchronised input level
  logic  on_req;     // one-cycle turn-on request
  logic  off_req;    // one-cycle turn-off request
  logic  active;     // two-state action currently held on

  // register side drives configuration, reads results
  modport ctl (output mode, output two_state,
               input level, input on_req, input off_req, input active);
  // conditioner side
  modport chan (input mode, input two_state,
                output level, output on_req, output off_req, output active);
endinterface

//--- hw/ttl_chan.sv
// one ttl input: synchroniser, edge detect and pulse qualifier
module ttl_chan
  import ttl_trig_pkg::*;
#(
  parameter logic [CNT_W-1:0] QUAL_CYCLES = CNT_W'(QUAL_CYC)
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ttl_i,
  chan_if.chan      ch
);

  logic             s1_q;    // first synchroniser stage
  logic             s2_q;    // second synchroniser stage
  logic             prev_q;  // level one cycle ago
  logic [CNT_W-1:0] cnt_q;   // active-level width counter
  logic             done_q;  // this pulse already fired
  logic             on_q;
  logic             off_q;
  logic             act_q;

  // active level: low normally, high when inverted
  wire logic inv     = ch.mode[MODE_INV];
  wire logic pulse   = ch.mode[MODE_PULSE];
  wire logic act_now = s2_q ^ ~inv;
  wire logic act_old = prev_q ^ ~inv;
  wire logic lead    = act_now & ~act_old;
  wire logic trail   = ~act_now & act_old;
  wire logic reached = (cnt_q == QUAL_CYCLES);

  // two flops before any logic looks at the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q   <= LINE_RST;
      s2_q   <= LINE_RST;
      prev_q <= LINE_RST;
    end else begin
      s1_q   <= ttl_i;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  // width counter runs only while the line is active in pulse type
  always_ff @(posedge clk_i) begin
    if (rst_i || !pulse || !act_now) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      cnt_q  <= cnt_q + CNT_W'(1);
      done_q <= reached;
    end
  end

  // request generation per trigger type
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_q  <= 1'b0;
      off_q <= 1'b0;
      act_q <= 1'b0;
    end else if (pulse) begin
      on_q  <= reached & ~done_q & act_now;
      off_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      on_q  <= lead;
      off_q <= trail & ch.two_state;
      act_q <= ch.two_state & act_now;
    end
  end

  assign ch.level   = s2_q;
  assign ch.on_req  = on_q;
  assign ch.off_req = off_q;
  assign ch.active  = act_q;

endmodule

//--- hw/ttl_input_action_trigger.sv
// ttl input action trigger: eight conditioned inputs behind wishbone
//
// What this block does
// - four trigger types per input, selectable
// - reset selects normal edge on every input
// - normal edge: falling edge requests turn-on
// - two-state action: rising edge requests turn-off
// - single-state action: trailing edge issues nothing
// - two-state action held while input active
// - inverted edge swaps rising and falling roles
// - normal pulse: falling active, rising ignored
// - pulses of fifty ms always fire
// - pulses of four ms or less rejected
// - inverted pulse swaps rising and falling roles
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
module ttl_input_action_trigger
  import ttl_trig_pkg::*;
#(
  // qualification width in cycles, shortenable for simulation
  parameter logic [CNT_W-1:0] QUAL_CYCLES = CNT_W'(ttl_trig_pkg::QUAL_CYC)
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // external ttl lines, asynchronous
  input  wire logic [ttl_trig_pkg::NUM_IN-1:0] ttl_i,
  // wishbone classic slave
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [ttl_trig_pkg::ADR_W-1:0]  adr_i,
  input  wire logic [3:0]                     sel_i,
  input  wire logic [ttl_trig_pkg::DAT_W-1:0]  dat_i,
  output logic      [ttl_trig_pkg::DAT_W-1:0]  dat_o,
  output logic                                ack_o,
  // action dispatch side
  output logic      [ttl_trig_pkg::NUM_IN-1:0] on_req_o,
  output logic      [ttl_trig_pkg::NUM_IN-1:0] off_req_o,
  output logic      [ttl_trig_pkg::NUM_IN-1:0] active_o
);

  import ttl_trig_pkg::*;

  // ------------------------------------------------------------
  // configuration and event state
  // ------------------------------------------------------------

  // trigger type per input, two bits each
  logic [15:0]       mode_q;
  // per input: assigned action has on and off states
  logic [7:0]        kind_q;
  // sticky turn-on and turn-off events
  logic [15:0]       evt_q;
  logic [15:0]       evt_d;

  // wishbone answer path
  logic              ack_q;
  logic [DAT_W-1:0]  dat_q;

  // registered dispatch outputs
  logic [NUM_IN-1:0] on_q;
  logic [NUM_IN-1:0] off_q;
  logic [NUM_IN-1:0] act_q;

  // gathered channel results
  logic [NUM_IN-1:0] level_w;
  logic [NUM_IN-1:0] on_w;
  logic [NUM_IN-1:0] off_w;
  logic [NUM_IN-1:0] act_w;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------

  // a live request from the master
  wire logic req      = cyc_i & stb_i;
  // first cycle of a request: latch read data
  wire logic req_new  = req & ~ack_q;
  // write commits on the edge where ack is seen high
  wire logic wr_fire  = req & ack_q & we_i;

  // address matches, word aligned
  wire logic hit_mode = (adr_i == OFS_MODE);
  wire logic hit_kind = (adr_i == OFS_KIND);
  wire logic hit_stat = (adr_i == OFS_STATUS);
  wire logic hit_evt  = (adr_i == OFS_EVENT);

  // per-register write strobes
  wire logic wr_mode  = wr_fire & hit_mode;
  wire logic wr_kind  = wr_fire & hit_kind;
  wire logic wr_evt   = wr_fire & hit_evt;

  // byte-lane masks for the sixteen-bit registers
  wire logic [15:0] lane16 = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  // status word: levels and held actions
  wire logic [DAT_W-1:0] stat_w = {16'h0000, act_q, level_w};

  // read mux, unmapped words read as zero
  wire logic [DAT_W-1:0] rdata =
      hit_mode ? {16'h0000, mode_q} :
      hit_kind ? {24'h00_0000, kind_q} :
      hit_stat ? stat_w :
      hit_evt  ? {16'h0000, evt_q} :
                 32'h0000_0000;

  // ------------------------------------------------------------
  // wishbone handshake
  // ------------------------------------------------------------

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_new;
    end
  end

  // read data captured with the request, held through ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (req_new) begin
      dat_q <= rdata;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------

  // trigger type per input, normal edge after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_RST;
    end else if (wr_mode) begin
      // masked update of enabled byte lanes
      mode_q <= (mode_q & ~lane16) | (dat_i[15:0] & lane16);
    end
  end

  // action kind per input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind_q <= KIND_RST;
    end else if (wr_kind && sel_i[0]) begin
      kind_q <= dat_i[7:0];
    end
  end

  // ------------------------------------------------------------
  // sticky events, write one to clear
  // ------------------------------------------------------------

  // clear first, then new events so a set wins
  always_comb begin
    evt_d = evt_q;
    if (wr_evt) begin
      evt_d = evt_d & ~(dat_i[15:0] & lane16);
    end
    evt_d = evt_d | {off_w, on_w};
  end

  // event register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= '0;
    end else begin
      evt_q <= evt_d;
    end
  end

  // ------------------------------------------------------------
  // input channels
  // ------------------------------------------------------------

  // one conditioner per ttl line
  for (genvar i = 0; i < NUM_IN; i++) begin : g_chan

    // link to this channel
    chan_if ch ();

    // configuration handed down
    assign ch.mode      = trig_e'(mode_q[i*MODE_BITS +: MODE_BITS]);
    assign ch.two_state = kind_q[i];

    // results gathered back
    assign level_w[i]   = ch.level;
    assign on_w[i]      = ch.on_req;
    assign off_w[i]     = ch.off_req;
    assign act_w[i]     = ch.active;

    // conditioner with shared width threshold
    ttl_chan #(
      .QUAL_CYCLES (QUAL_CYCLES)
    ) u_chan (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ttl_i (ttl_i[i]),
      .ch    (ch.chan)
    );
  end

  // ------------------------------------------------------------
  // dispatch outputs
  // ------------------------------------------------------------

  // requests and held states leave from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_q  <= '0;
      off_q <= '0;
      act_q <= '0;
    end else begin
      on_q  <= on_w;
      off_q <= off_w;
      act_q <= act_w;
    end
  end

  // ------------------------------------------------------------
  // port drive
  // ------------------------------------------------------------

  // bus answer
  assign ack_o     = ack_q;
  assign dat_o     = dat_q;

  // dispatch
  assign on_req_o  = on_q;
  assign off_req_o = off_q;
  assign active_o  = act_q;

endmodule

//--- tb/ttl_trig_monitor.sv
// assertions on the ttl trigger top ports
module ttl_trig_monitor
  import ttl_trig_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [NUM_IN-1:0] ttl_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [ADR_W-1:0]  adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [DAT_W-1:0]  dat_i,
  input wire logic              ack_o,
  input wire logic [NUM_IN-1:0] on_req_o,
  input wire logic [NUM_IN-1:0] off_req_o,
  input wire logic [NUM_IN-1:0] active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_q;               // line 0 type, snooped
  wire act = ~ttl_i[0] ^ mode_q[0]; // line 0 at active level
  // follow accepted writes to the mode byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= 2'h0;
    end else if (ack_o && we_i && sel_i[0] && adr_i == OFS_MODE) begin
      mode_q <= dat_i[1:0];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_on_edge; !mode_q[1] && $rose(act) && $stable(mode_q) |-> ##[2:6] on_req_o[0];
  endproperty
  a_on_edge: assert property (p_on_edge) else $error("edge missed");
  property p_act_rise; $rose(active_o[0]) && mode_q == $past(mode_q, 3) |-> on_req_o[0];
  endproperty
  a_act_rise: assert property (p_act_rise) else $error("hold w/o on");
  property p_act_drop;
    $fell(active_o[0]) && mode_q == $past(mode_q, 3) |-> off_req_o[0] || $past(off_req_o[0]);
  endproperty
  a_act_drop: assert property (p_act_drop) else $error("hold lost");
  property p_off_clear; off_req_o[0] |=> !active_o[0]; endproperty
  a_off_clear: assert property (p_off_clear) else $error("still held");
  property p_pulse_nooff; mode_q[1] && mode_q == $past(mode_q, 8) |-> !off_req_o[0];
  endproperty
  a_pulse_nooff: assert property (p_pulse_nooff) else $error("pulse off");
  property p_on_once; on_req_o[0] |=> !on_req_o[0]; endproperty
  a_on_once: assert property (p_on_once) else $error("on twice");
  c_pulse: cover property (mode_q[1] && on_req_o[0]);
  c_off: cover property (off_req_o[0]);
  c_hold: cover property (active_o[0]);
endmodule

//--- tb/ttl_src.sv
// instrument model driving the ttl lines, idle high
module ttl_src
  import ttl_trig_pkg::*;
(
  input  wire logic              clk_i,
  output logic      [NUM_IN-1:0] ttl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ttl_o = '1;  // lines pulled up when idle
  // move line 0 after an edge and hold it n cycles
  task automatic hold(input logic v, input int n);
    @(posedge clk_i);
    ttl_o[0] <= v;
    repeat (n) @(posedge clk_i);
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the ttl input action trigger
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ttl_trig_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;  // clock, reset, bus
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o;
  logic [7:0] ttl_i, on_req_o, off_req_o, active_o;
  int err_count = 0;
  int checks_done = 0;
  int on_n = 0;   // line 0 turn-on tally
  int off_n = 0;  // line 0 turn-off tally
  int oth_n = 0;  // requests on the idle lines 1 to 7
  ttl_src u_src (.clk_i(clk_i), .ttl_o(ttl_i));
  // qualification shortened to 20 cycles
  ttl_input_action_trigger #(.QUAL_CYCLES(24'h00_0014)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ttl_i(ttl_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .on_req_o(on_req_o), .off_req_o(off_req_o), .active_o(active_o));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // tally requests away from the active edge
  always @(negedge clk_i) begin
    on_n += int'(on_req_o[0] === 1'b1);
    off_n += int'(off_req_o[0] === 1'b1);
    oth_n += int'((|{on_req_o[7:1], off_req_o[7:1]}) === 1'b1);
  end
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic bus cycle; reads compare with e
  task automatic wb(input logic w, input logic [3:0] a, s, input logic [31:0] d, e);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    n = 0;
    // wait for the edge that samples ack high, bounded
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    chk({31'h0, ack_o}, 32'h0000_0001);
    if (!w) begin
      chk(dat_o, e);
    end
    // release right after the ack edge, then idle one cycle
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // let requests land, compare all tallies and clear the line 0 ones
  task automatic expect_n(input int on_e, input int off_e);
    repeat (12) @(posedge clk_i);
    chk(on_n, on_e);
    chk(off_n, off_e);
    chk(oth_n, 0);
    on_n = 0;
    off_n = 0;
  endtask
  // print counts and verdict, then stop
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // reset values, dead lanes, unmapped place
  task automatic t_reset();
    wb(1, OFS_MODE, 4'h0, 32'h0000_0002, 0);
    wb(0, OFS_MODE, 4'hF, 0, 32'h0000_0000);
    wb(0, OFS_KIND, 4'hF, 0, 32'h0000_00FF);
    wb(0, OFS_STATUS, 4'hF, 0, 32'h0000_00FF);
    wb(1, 4'h1, 4'hF, 32'hFFFF_FFFF, 0);
    wb(0, 4'h1, 4'hF, 0, 32'h0000_0000);
  endtask
  // normal edge, two-state action held while low
  task automatic t_edge();
    u_src.hold(1'b0, 30);
    chk({24'h00_0000, active_o}, 32'h0000_0001);
    wb(0, OFS_STATUS, 4'hF, 0, 32'h0000_01FE);
    u_src.hold(1'b1, 1);
    expect_n(1, 1);
    wb(0, OFS_STATUS, 4'hF, 0, 32'h0000_00FF);
    wb(0, OFS_EVENT, 4'hF, 0, 32'h0000_0101);
    wb(1, OFS_EVENT, 4'hF, 32'h0000_0101, 0);
    wb(0, OFS_EVENT, 4'hF, 0, 32'h0000_0000);
  endtask
  // single-state action ignores the trailing edge
  task automatic t_single();
    wb(1, OFS_KIND, 4'hF, 32'h0000_00FE, 0);
    u_src.hold(1'b0, 20);
    u_src.hold(1'b1, 1);
    expect_n(1, 0);
    wb(1, OFS_KIND, 4'hF, 32'h0000_00FF, 0);
  endtask
  // normal pulse: short dropped, long fires once
  task automatic t_pulse();
    wb(1, OFS_MODE, 4'hF, 32'h0000_0002, 0);
    u_src.hold(1'b0, 4);
    u_src.hold(1'b1, 1);
    expect_n(0, 0);
    u_src.hold(1'b0, 60);
    u_src.hold(1'b1, 1);
    expect_n(1, 0);
  endtask
  // inverted edge, then inverted pulse
  task automatic t_inv();
    wb(1, OFS_MODE, 4'hF, 32'h0000_0001, 0);
    u_src.hold(1'b0, 1);
    expect_n(0, 1);
    u_src.hold(1'b1, 1);
    expect_n(1, 0);
    u_src.hold(1'b0, 1);
    expect_n(0, 1);
    wb(1, OFS_MODE, 4'hF, 32'h0000_0003, 0);
    u_src.hold(1'b1, 4);
    u_src.hold(1'b0, 1);
    expect_n(0, 0);
    u_src.hold(1'b1, 60);
    u_src.hold(1'b0, 1);
    expect_n(1, 0);
  endtask
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 4'h0;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_edge();
    t_single();
    t_pulse();
    t_inv();
    end_of_test();
  end
  // cut a hang short
  initial begin
    #20us;
    err_count++;
    end_of_test();
  end
endmodule
bind ttl_input_action_trigger ttl_trig_monitor u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .ttl_i(ttl_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
  .on_req_o(on_req_o), .off_req_o(off_req_o), .active_o(active_o));
